// >>> blr_cfg_regs.sv
// blr_cfg_regs.sv: link-layer radio, advertising and cipher configuration registers
// assumes an axi4-lite master on clk; outputs feed the sequencer and cipher engine
//
// Contract
// - hold seven-bit round trip latency
// - rx power-up length, resets to 210
// - tx power-down extension, resets to 3
// - tx power-up length, resets to 210
// - channel map bit i enables channel i+37
// - fourteen-bit advertising packet spacing in microseconds
// - back-off counter initial value, nine bits
// - nine-bit scan counter upper limit
// - public filter list base address
// - private filter list base address
// - private count upper byte, public lower
// - writing one starts cipher on key
// - start bit clears while done event is high
// - key assembled from four words, low first
// - block pointer for cipher data fetch
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "blr_params.svh"
module blr_cfg_regs
  import blr_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = `BLR_CYCLES_PER_US
)
(
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration outputs
  output logic [4:0] radio_select_field,
  output logic [6:0] round_trip_latency,
  output logic [7:0] rx_powerup_time,
  output logic [3:0] tx_powerdown_extension,
  output logic [7:0] tx_powerup_time,
  output logic [2:0] adv_channel_enables,
  output logic [13:0] adv_packet_spacing,
  output logic [8:0] scan_init_a,
  output logic [8:0] scan_counter_limit,
  output logic [15:0] public_list_base,
  output logic [15:0] private_list_base,
  output logic [7:0] private_entry_count,
  output logic [7:0] public_entry_count,
  output logic [127:0] cipher_key,
  output logic [15:0] cipher_block_pointer,
  output logic cipher_start_pulse,
  input wire logic cipher_done_event,
  output logic us_tick,
  // interval timer for advertising, pulses each elapsed spacing
  input wire logic adv_run,
  output logic adv_slot_pulse,
  output logic irq
);
  initial
  begin
    if (CYCLES_PER_US < 1) $error("cycles per microsecond must be at least one");
  end

  // write with byte enables onto an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    return r;
  endfunction : merge

  // address decode, shared by read and write paths
  function automatic logic mapped(input logic [31:0] a);
    logic m;
    m = 1'b0;
    case (a)
      `BLR_OFF_RADIO_EXT_SELECT, `BLR_OFF_RADIO_POWER_TIMING, `BLR_OFF_ADV_CHANNEL_MAP,
      `BLR_OFF_ADV_INTERVAL, `BLR_OFF_ACTIVE_SCAN, `BLR_OFF_PUBLIC_LIST,
      `BLR_OFF_PRIVATE_LIST, `BLR_OFF_LIST_COUNTS, `BLR_OFF_CIPHER_CONTROL,
      `BLR_OFF_KEY_WORD0, `BLR_OFF_KEY_WORD1, `BLR_OFF_KEY_WORD2, `BLR_OFF_KEY_WORD3,
      `BLR_OFF_BLOCK_POINTER, `BLR_OFF_IRQ_STATUS, `BLR_OFF_IRQ_MASK:
        m = 1'b1;
      default:
        m = 1'b0;
    endcase
    return m;
  endfunction : mapped

  // register storage, full words with reserved bits held at zero, except the narrow start and irq bits
  logic [31:0] ext_select_q;
  logic [31:0] power_timing_q;
  logic [31:0] adv_map_q;
  logic [31:0] adv_interval_q;
  logic [31:0] active_scan_q;
  logic [31:0] public_ptr_q;
  logic [31:0] private_ptr_q;
  logic [31:0] counts_q;
  logic start_q; // cipher start bit, busy while set
  logic [31:0] key_q [4]; // key words, index 0 is the low word
  logic [31:0] block_ptr_q;
  logic [1:0] irq_status_q; // bit0 cipher done, bit1 adv slot
  logic [1:0] irq_mask_q;

  // write channel capture: address and data may arrive in either order
  logic aw_held_q;
  logic w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // write address and data latches; ready only while the slot is empty
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
      // drop ready right after a take so no second item slips in
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BLR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(awaddr_q) ? BLR_RESP_OKAY : BLR_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // plain configuration words; only documented field bits are kept
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_select_q <= '0;
      power_timing_q <= `BLR_RST_POWER_TIMING;
      adv_map_q <= `BLR_RST_ADV_MAP;
      adv_interval_q <= '0;
      active_scan_q <= '0;
      public_ptr_q <= '0;
      private_ptr_q <= '0;
      counts_q <= '0;
      block_ptr_q <= '0;
      irq_mask_q <= '0;
      for (int i = 0; i < 4; i++)
        key_q[i] <= '0;
    end
    else if (wr_fire)
    begin
      case (awaddr_q)
        `BLR_OFF_RADIO_EXT_SELECT:
          ext_select_q <= merge(ext_select_q, wdata_q, wstrb_q) & 32'h001f_0000;
        `BLR_OFF_RADIO_POWER_TIMING:
          power_timing_q <= merge(power_timing_q, wdata_q, wstrb_q) & 32'h7fff_0fff;
        `BLR_OFF_ADV_CHANNEL_MAP:
          adv_map_q <= merge(adv_map_q, wdata_q, wstrb_q) & 32'h0000_0007;
        `BLR_OFF_ADV_INTERVAL:
          adv_interval_q <= merge(adv_interval_q, wdata_q, wstrb_q) & 32'h0000_3fff;
        `BLR_OFF_ACTIVE_SCAN:
          active_scan_q <= merge(active_scan_q, wdata_q, wstrb_q) & 32'h01ff_01ff;
        `BLR_OFF_PUBLIC_LIST:
          public_ptr_q <= merge(public_ptr_q, wdata_q, wstrb_q) & 32'h0000_ffff;
        `BLR_OFF_PRIVATE_LIST:
          private_ptr_q <= merge(private_ptr_q, wdata_q, wstrb_q) & 32'h0000_ffff;
        `BLR_OFF_LIST_COUNTS:
          counts_q <= merge(counts_q, wdata_q, wstrb_q) & 32'h0000_ffff;
        `BLR_OFF_KEY_WORD0:
          key_q[0] <= merge(key_q[0], wdata_q, wstrb_q);
        `BLR_OFF_KEY_WORD1:
          key_q[1] <= merge(key_q[1], wdata_q, wstrb_q);
        `BLR_OFF_KEY_WORD2:
          key_q[2] <= merge(key_q[2], wdata_q, wstrb_q);
        `BLR_OFF_KEY_WORD3:
          key_q[3] <= merge(key_q[3], wdata_q, wstrb_q);
        `BLR_OFF_BLOCK_POINTER:
          block_ptr_q <= merge(block_ptr_q, wdata_q, wstrb_q) & 32'h0000_ffff;
        `BLR_OFF_IRQ_MASK:
          irq_mask_q <= wstrb_q[0] ? wdata_q[1:0] : irq_mask_q;
        default:
          ;
      endcase
    end
  end

  // cipher start: a written one starts; the done event clears, even when masked
  logic start_wr;
  assign start_wr = wr_fire && (awaddr_q == `BLR_OFF_CIPHER_CONTROL) && wstrb_q[0]
                    && wdata_q[`BLR_START_BIT];
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_q <= 1'b0;
      cipher_start_pulse <= 1'b0;
    end
    else
    begin
      // a new start only while idle; a write during a run changes nothing
      cipher_start_pulse <= start_wr && !start_q;
      if (cipher_done_event)
        start_q <= 1'b0;
      else if (start_wr)
        start_q <= 1'b1;
    end
  end

  // microsecond tick and the advertising spacing timer
  logic tick_w;
  logic adv_busy;
  logic adv_done;
  logic adv_start;
  blr_us_tick #(.CYCLES_PER_US(CYCLES_PER_US)) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick_w)
  );
  assign adv_start = adv_run && !adv_busy && !adv_done;
  blr_us_timer #(.WIDTH(14)) u_adv_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick_w),
    .start(adv_start),
    .length(adv_interval_q[13:0]),
    .busy(adv_busy),
    .done(adv_done)
  );

  // sticky interrupt status; set wins over a write-one clear
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  // a slot that ends after run drops is swallowed, so no late slot follows a stop
  assign irq_set = {adv_done && adv_run, cipher_done_event};
  assign irq_clr = (wr_fire && awaddr_q == `BLR_OFF_IRQ_STATUS && wstrb_q[0]) ?
                   wdata_q[1:0] : 2'b00;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_status_q <= '0;
      irq <= 1'b0;
      adv_slot_pulse <= 1'b0;
      us_tick <= 1'b0;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      irq <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_mask_q);
      adv_slot_pulse <= adv_done && adv_run;
      us_tick <= tick_w;
    end
  end

  // read channel: one read at a time, data registered
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= BLR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? BLR_RESP_OKAY : BLR_RESP_SLVERR;
        case (s_axi_araddr)
          `BLR_OFF_RADIO_EXT_SELECT: s_axi_rdata <= ext_select_q;
          `BLR_OFF_RADIO_POWER_TIMING: s_axi_rdata <= power_timing_q;
          `BLR_OFF_ADV_CHANNEL_MAP: s_axi_rdata <= adv_map_q;
          `BLR_OFF_ADV_INTERVAL: s_axi_rdata <= adv_interval_q;
          `BLR_OFF_ACTIVE_SCAN: s_axi_rdata <= active_scan_q;
          `BLR_OFF_PUBLIC_LIST: s_axi_rdata <= public_ptr_q;
          `BLR_OFF_PRIVATE_LIST: s_axi_rdata <= private_ptr_q;
          `BLR_OFF_LIST_COUNTS: s_axi_rdata <= counts_q;
          `BLR_OFF_CIPHER_CONTROL: s_axi_rdata <= {31'd0, start_q}; // busy readback
          `BLR_OFF_KEY_WORD0: s_axi_rdata <= key_q[0];
          `BLR_OFF_KEY_WORD1: s_axi_rdata <= key_q[1];
          `BLR_OFF_KEY_WORD2: s_axi_rdata <= key_q[2];
          `BLR_OFF_KEY_WORD3: s_axi_rdata <= key_q[3];
          `BLR_OFF_BLOCK_POINTER: s_axi_rdata <= block_ptr_q;
          `BLR_OFF_IRQ_STATUS: s_axi_rdata <= {30'd0, irq_status_q};
          `BLR_OFF_IRQ_MASK: s_axi_rdata <= {30'd0, irq_mask_q};
          default: s_axi_rdata <= '0;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // field outputs registered so every output comes from a flip-flop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      radio_select_field <= '0;
      round_trip_latency <= '0;
      rx_powerup_time <= 8'h00;
      tx_powerdown_extension <= 4'h0;
      tx_powerup_time <= 8'h00;
      adv_channel_enables <= 3'h0;
      adv_packet_spacing <= '0;
      scan_init_a <= '0;
      scan_counter_limit <= '0;
      public_list_base <= '0;
      private_list_base <= '0;
      private_entry_count <= '0;
      public_entry_count <= '0;
      cipher_key <= '0;
      cipher_block_pointer <= '0;
    end
    else
    begin
      radio_select_field <= ext_select_q[`BLR_RADIO_SELECT_MSB:`BLR_RADIO_SELECT_LSB];
      round_trip_latency <= power_timing_q[`BLR_RTRIP_MSB:`BLR_RTRIP_LSB];
      rx_powerup_time <= power_timing_q[`BLR_RXPU_MSB:`BLR_RXPU_LSB];
      tx_powerdown_extension <= power_timing_q[`BLR_TXPD_MSB:`BLR_TXPD_LSB];
      tx_powerup_time <= power_timing_q[`BLR_TXPU_MSB:`BLR_TXPU_LSB];
      adv_channel_enables <= adv_map_q[2:0];
      adv_packet_spacing <= adv_interval_q[13:0];
      scan_init_a <= active_scan_q[`BLR_SCAN_INIT_A_MSB:`BLR_SCAN_INIT_A_LSB];
      scan_counter_limit <= active_scan_q[8:0];
      public_list_base <= public_ptr_q[15:0];
      private_list_base <= private_ptr_q[15:0];
      private_entry_count <= counts_q[`BLR_PRIV_CNT_MSB:`BLR_PRIV_CNT_LSB];
      public_entry_count <= counts_q[7:0];
      cipher_key <= {key_q[3], key_q[2], key_q[1], key_q[0]};
      cipher_block_pointer <= block_ptr_q[15:0];
    end
  end
endmodule : blr_cfg_regs

// >>> blr_params.svh
// blr_params.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name; definitions only
`ifndef BLR_PARAMS_SVH
`define BLR_PARAMS_SVH
`define BLR_OFF_RADIO_EXT_SELECT 32'h4000_0074
`define BLR_OFF_RADIO_POWER_TIMING 32'h4000_0080
`define BLR_OFF_ADV_CHANNEL_MAP 32'h4000_0090
`define BLR_OFF_ADV_INTERVAL 32'h4000_00a0
`define BLR_OFF_ACTIVE_SCAN 32'h4000_00a4
`define BLR_OFF_PUBLIC_LIST 32'h4000_00b0
`define BLR_OFF_PRIVATE_LIST 32'h4000_00b4
`define BLR_OFF_LIST_COUNTS 32'h4000_00b8
`define BLR_OFF_CIPHER_CONTROL 32'h4000_00c0
`define BLR_OFF_KEY_WORD0 32'h4000_00c4
`define BLR_OFF_KEY_WORD1 32'h4000_00c8
`define BLR_OFF_KEY_WORD2 32'h4000_00cc
`define BLR_OFF_KEY_WORD3 32'h4000_00d0
`define BLR_OFF_BLOCK_POINTER 32'h4000_00d4
`define BLR_OFF_IRQ_STATUS 32'h4000_00e8
`define BLR_OFF_IRQ_MASK 32'h4000_00ec
`define BLR_RST_POWER_TIMING 32'h00d2_03d2
`define BLR_RST_ADV_MAP 32'h0000_0007
`define BLR_RADIO_SELECT_LSB 16
`define BLR_RADIO_SELECT_MSB 20
`define BLR_RTRIP_LSB 24
`define BLR_RTRIP_MSB 30
`define BLR_RXPU_LSB 16
`define BLR_RXPU_MSB 23
`define BLR_TXPD_LSB 8
`define BLR_TXPD_MSB 11
`define BLR_TXPU_LSB 0
`define BLR_TXPU_MSB 7
`define BLR_SCAN_INIT_A_LSB 16
`define BLR_SCAN_INIT_A_MSB 24
`define BLR_PRIV_CNT_LSB 8
`define BLR_PRIV_CNT_MSB 15
`define BLR_START_BIT 0
`define BLR_CLK_MHZ 100
`define BLR_CYCLES_PER_US (`BLR_CLK_MHZ * 1000 / 1000)
`endif

// >>> blr_pkg.sv
// blr_pkg.sv: types shared by the configuration register block
// assumes blr_params.svh is compiled alongside
package blr_pkg;
  // microsecond timer states, gray along idle, run, done
  typedef enum logic [1:0] {
    BLR_T_IDLE = 2'b00,
    BLR_T_RUN = 2'b01,
    BLR_T_DONE = 2'b11
  } blr_tstate_t;
  // axi response codes
  typedef enum logic [1:0] {
    BLR_RESP_OKAY = 2'b00,
    BLR_RESP_SLVERR = 2'b10
  } blr_resp_t;
endpackage : blr_pkg

// >>> blr_us_tick.sv
// blr_us_tick.sv: one-microsecond tick divider from the core clock
// assumes a free-running clk at the rate set by the parameter
`timescale 1ns/1ns
`include "blr_params.svh"
module blr_us_tick
  import blr_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = `BLR_CYCLES_PER_US
)
(
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  localparam int unsigned W = (CYCLES_PER_US > 1) ? $clog2(CYCLES_PER_US) : 1;
  logic [W-1:0] div_q; // cycle counter within a microsecond
  initial
  begin
    if (CYCLES_PER_US < 1) $error("cycles per microsecond must be at least one");
  end
  // divider: tick is one cycle high every microsecond
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q <= '0;
      tick <= 1'b0;
    end
    else if (div_q == W'(CYCLES_PER_US - 1))
    begin
      div_q <= '0;
      tick <= 1'b1;
    end
    else
    begin
      div_q <= div_q + W'(1);
      tick <= 1'b0;
    end
  end
endmodule : blr_us_tick

// >>> blr_us_timer.sv
// blr_us_timer.sv: microsecond delay timer, loaded with a length and started
// assumes tick from blr_us_tick; a length of zero finishes at once
`timescale 1ns/1ns
module blr_us_timer
  import blr_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  output logic busy,
  output logic done
);
  blr_tstate_t st_q; // timer state
  logic [WIDTH-1:0] cnt_q; // microseconds left
  initial
  begin
    if (WIDTH < 1) $error("timer width must be at least one");
  end
  // countdown; zero length gives a done pulse next cycle, no added delay
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= BLR_T_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (st_q)
        BLR_T_IDLE:
        begin
          if (start)
          begin
            cnt_q <= length;
            st_q <= (length == '0) ? BLR_T_DONE : BLR_T_RUN;
          end
        end
        BLR_T_RUN:
        begin
          if (tick)
          begin
            // last microsecond elapsed
            if (cnt_q == WIDTH'(1))
              st_q <= BLR_T_DONE;
            cnt_q <= cnt_q - WIDTH'(1);
          end
        end
        BLR_T_DONE:
          st_q <= BLR_T_IDLE;
        default:
          st_q <= BLR_T_IDLE;
      endcase
    end
  end
  assign busy = (st_q == BLR_T_RUN);
  assign done = (st_q == BLR_T_DONE);
endmodule : blr_us_timer

// >>> blr_cfg_regs_sva.sv
// blr_cfg_regs_sva.sv: concurrent checks on the register block ports
// assumes one clock domain, async active-low reset, bound to every blr_cfg_regs
`timescale 1ns/1ns
module blr_cfg_regs_chk
  import blr_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = 100
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] rx_powerup_time,
  input wire logic [7:0] tx_powerup_time,
  input wire logic [3:0] tx_powerdown_extension,
  input wire logic [2:0] adv_channel_enables,
  input wire logic [8:0] scan_init_a,
  input wire logic [127:0] cipher_key,
  input wire logic cipher_start_pulse,
  input wire logic adv_run,
  input wire logic adv_slot_pulse,
  input wire logic us_tick,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] gap_q; // cycles since the last tick
  logic seen_q; // first tick after reset has no reference point
  // tick spacing counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end
    else if (us_tick)
    begin
      gap_q <= '0;
      seen_q <= 1'b1;
    end
    else
      gap_q <= gap_q + 8'h01;
  end
  chk_reset_values: assert property ($rose(reset_n) |=>
    rx_powerup_time == 8'hd2 && tx_powerup_time == 8'hd2 &&
    tx_powerdown_extension == 4'h3 && adv_channel_enables == 3'h7)
    else $error("wrong reset values");
  chk_start_single: assert property (cipher_start_pulse |=> !cipher_start_pulse)
    else $error("start pulse too long");
  chk_start_cause: assert property (cipher_start_pulse |->
    $past(s_axi_bvalid) or ##[0:2] s_axi_bvalid)
    else $error("start pulse without a write");
  chk_cfg_on_write: assert property (($changed(cipher_key) || $changed(scan_init_a))
    && $past(reset_n) |-> $past(s_axi_bvalid) or ##[0:2] s_axi_bvalid)
    else $error("config changed without write");
  chk_slot_needs_run: assert property (adv_slot_pulse |->
    $past(adv_run) || $past(adv_run, 2) || $past(adv_run, 3))
    else $error("slot while stopped");
  chk_tick_period: assert property (us_tick && seen_q |->
    gap_q == 8'(CYCLES_PER_US - 1))
    else $error("tick spacing wrong");
  chk_write_answer: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  cov_start: cover property (cipher_start_pulse);
  cov_irq: cover property ($rose(irq));
  cov_slot: cover property (adv_slot_pulse);
endmodule : blr_cfg_regs_chk
bind blr_cfg_regs blr_cfg_regs_chk #(.CYCLES_PER_US(CYCLES_PER_US)) u_chk (.*);

// >>> tb_blr_cfg_regs.sv
// tb_blr_cfg_regs.sv: self-checking bench for the configuration register block
// assumes design, package and header compiled first
`timescale 1ns/1ns
`include "blr_params.svh"
module tb_blr_cfg_regs
  import blr_pkg::*;
;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} blr_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cipher_done_event = 1'b0, adv_run = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] radio_select_field;
  logic [6:0] round_trip_latency;
  logic [7:0] rx_powerup_time, tx_powerup_time, private_entry_count, public_entry_count;
  logic [3:0] tx_powerdown_extension;
  logic [2:0] adv_channel_enables;
  logic [13:0] adv_packet_spacing;
  logic [8:0] scan_init_a, scan_counter_limit;
  logic [15:0] public_list_base, private_list_base, cipher_block_pointer;
  logic [127:0] cipher_key;
  logic cipher_start_pulse, us_tick, adv_slot_pulse, irq;
  logic [31:0] rd; // last read data
  int mismatches = 0, n_tests = 0, n_start = 0, n_slot = 0, n_tick = 0, k = 0;
  // rows: address, write value, expected read-back
  blr_row_t rows [16] = '{
    '{`BLR_OFF_RADIO_EXT_SELECT, 32'hffff_ffff, 32'h001f_0000},
    '{`BLR_OFF_RADIO_EXT_SELECT, 32'h0003_0000, 32'h0003_0000},
    '{`BLR_OFF_RADIO_POWER_TIMING, 32'hffff_ffff, 32'h7fff_0fff},
    '{`BLR_OFF_ADV_CHANNEL_MAP, 32'hffff_ffff, 32'h0000_0007},
    '{`BLR_OFF_ADV_CHANNEL_MAP, 32'h0000_0005, 32'h0000_0005},
    '{`BLR_OFF_ADV_INTERVAL, 32'hffff_ffff, 32'h0000_3fff},
    '{`BLR_OFF_ACTIVE_SCAN, 32'hffff_ffff, 32'h01ff_01ff},
    '{`BLR_OFF_PUBLIC_LIST, 32'hffff_ffff, 32'h0000_ffff},
    '{`BLR_OFF_PRIVATE_LIST, 32'h1234_abcd, 32'h0000_abcd},
    '{`BLR_OFF_LIST_COUNTS, 32'hffff_5a3c, 32'h0000_5a3c},
    '{`BLR_OFF_KEY_WORD0, 32'h1111_1111, 32'h1111_1111},
    '{`BLR_OFF_KEY_WORD1, 32'h2222_2222, 32'h2222_2222},
    '{`BLR_OFF_KEY_WORD2, 32'h3333_3333, 32'h3333_3333},
    '{`BLR_OFF_KEY_WORD3, 32'h4444_4444, 32'h4444_4444},
    '{`BLR_OFF_BLOCK_POINTER, 32'hffff_ffff, 32'h0000_ffff},
    '{`BLR_OFF_ADV_INTERVAL, 32'h0000_0003, 32'h0000_0003}};
  // short microsecond keeps the timer scenarios brief
  blr_cfg_regs #(.CYCLES_PER_US(2)) DUT (.*);
  // clock, 10 ns period
  initial
  begin
    forever #5 clk = ~clk;
  end
  // pulse counters
  always @(posedge clk)
  begin
    if (cipher_start_pulse === 1'b1) n_start++;
    if (adv_slot_pulse === 1'b1) n_slot++;
    if (us_tick === 1'b1) n_tick++;
  end
  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  // reset for five cycles, then reset values
  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("rx_powerup_time", rx_powerup_time, 8'hd2);
    check("tx_powerup_time", tx_powerup_time, 8'hd2);
    check("tx_powerdown_extension", tx_powerdown_extension, 4'h3);
    check("adv_channel_enables", adv_channel_enables, 3'h7);
    check("cipher_key", cipher_key, 128'h0);
    rd_reg(`BLR_OFF_RADIO_POWER_TIMING);
    check("power timing reset", rd, 32'h00d2_03d2);
    rd_reg(`BLR_OFF_RADIO_EXT_SELECT);
    check("radio select reset", rd, 32'h0000_0000);
    $display("test reset done");
  endtask : do_reset
  // one cipher run: start, refused restart, done event, start bit cleared
  task automatic cipher_run(input logic [31:0] msk);
    wr(`BLR_OFF_IRQ_MASK, msk);
    k = n_start;
    wr(`BLR_OFF_CIPHER_CONTROL, 32'h0000_0001);
    rd_reg(`BLR_OFF_CIPHER_CONTROL);
    check("start bit busy", rd, 32'h0000_0001);
    wr(`BLR_OFF_CIPHER_CONTROL, 32'h0000_0001);
    check("start pulses", n_start - k, 1);
    cipher_done_event <= 1'b1;
    @(posedge clk);
    cipher_done_event <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq after done", irq, msk[0]);
    rd_reg(`BLR_OFF_CIPHER_CONTROL);
    check("start bit cleared", rd, 32'h0000_0000);
    rd_reg(`BLR_OFF_IRQ_STATUS);
    check("done status", rd, 32'h0000_0001);
    wr(`BLR_OFF_IRQ_STATUS, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check("irq cleared", irq, 1'b0);
  endtask : cipher_run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // watchdog, 20,000 cycles
  initial
  begin
    #200_000;
    mismatches++;
    end_sim();
  end
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      check("write response", rsp, BLR_RESP_OKAY);
      rd_reg(rows[i].a);
      check("read-back", rd, rows[i].e);
    end
    $display("test register table done");
    check("radio_select_field", radio_select_field, 5'b00011);
    check("round_trip_latency", round_trip_latency, 7'h7f);
    check("power times", {rx_powerup_time, tx_powerdown_extension, tx_powerup_time}, 20'hfffff);
    check("adv_channel_enables", adv_channel_enables, 3'b101);
    check("adv_packet_spacing", adv_packet_spacing, 14'h0003);
    check("scan fields", {scan_init_a, scan_counter_limit}, 18'h3_ffff);
    check("list bases", {public_list_base, private_list_base}, 32'hffff_abcd);
    check("counts", {private_entry_count, public_entry_count}, 16'h5a3c);
    check("cipher_key", cipher_key, 128'h4444_4444_3333_3333_2222_2222_1111_1111);
    check("cipher_block_pointer", cipher_block_pointer, 16'hffff);
    // byte strobe on the lowest key word touches only its low byte
    s_axi_wstrb <= 4'h1;
    wr(`BLR_OFF_KEY_WORD0, 32'haaaa_aaaa);
    s_axi_wstrb <= 4'hf;
    rd_reg(`BLR_OFF_KEY_WORD0);
    check("partial key word", rd, 32'h1111_11aa);
    check("cipher_key low", cipher_key[31:0], 32'h1111_11aa);
    // unmapped hole between radio select and power timing
    rd_reg(32'h4000_0078);
    check("unmapped read resp", rsp, BLR_RESP_SLVERR);
    check("unmapped read data", rd, 32'h0000_0000);
    wr(32'h4000_0078, 32'hffff_ffff);
    check("unmapped write resp", rsp, BLR_RESP_SLVERR);
    $display("test strobes and holes done");
    cipher_run(32'h0000_0001);
    cipher_run(32'h0000_0000);
    $display("test cipher done");
    // 3 us of 2 cycles plus idle and done states: a slot each 7 or 8 cycles
    k = n_tick;
    n_slot = 0;
    adv_run <= 1'b1;
    repeat (120) @(posedge clk);
    check("ticks in 120 cycles", n_tick - k, 60);
    check("slot count in range", n_slot >= 14 && n_slot <= 17, 1'b1);
    adv_run <= 1'b0;
    repeat (8) @(posedge clk);
    k = n_slot;
    repeat (30) @(posedge clk);
    check("no slots when stopped", n_slot - k, 0);
    rd_reg(`BLR_OFF_IRQ_STATUS);
    check("slot status", rd[1], 1'b1);
    $display("test advertising timer done");
    // second reset asserted on the edge that starts the advertising timer
    adv_run <= 1'b1;
    do_reset();
    adv_run <= 1'b0;
    end_sim();
  end
endmodule : tb_blr_cfg_regs
